// File: logic/event_select_map.svh
`ifndef EVENT_SELECT_MAP_SVH
`define EVENT_SELECT_MAP_SVH

// Register byte offsets on the register bus.
`define SELECT_ADDR     8'h00
`define COUNT_ADDR      8'h04
`define STATUS_ADDR     8'h08

// Reset values.
`define SELECT_RESET    32'h0000_0000
`define COUNT_RESET     32'h0000_0000

// Status field positions.
`define STATUS_KNOWN    0
`define STATUS_ABOVE    1

// Event numbers.
`define EV_FP128        8'h10
`define EV_VEC256       8'h11
`define EV_DIVIDER      8'h14
`define EV_L2_REQ       8'h24
`define EV_STORE_LOCK   8'h27
`define EV_WRITEBACK    8'h28
`define EV_LAST_LEVEL   8'h2E
`define EV_UNHALTED     8'h3C
`define EV_L1_PENDING   8'h48
`define EV_STORE_XLAT   8'h49

// Unit masks that are matched whole.
`define UM_LL_REFERENCE 8'h4F
`define UM_LL_MISS      8'h41
`define UM_CORE_CYCLES  8'h00
`define UM_REF_CYCLES   8'h01

// Only general counter two may take the outstanding-miss event.
`define GENERAL_COUNTER_TWO 2'h2

// Reference ticks carried by one change of the divided reference toggle.
`define REF_TICKS_PER_TOGGLE 5'h10

`endif

// File: logic/event_select_pkg.sv
package event_select_pkg;

  typedef struct packed {
    logic [7:0] countMask;
    logic [3:0] reserved;
    logic [1:0] counterIndex;
    logic       enable;
    logic       edgeDetect;
    logic [7:0] unitMask;
    logic [7:0] eventNum;
  } select_type;

  typedef struct packed {
    logic [2:0] fp128_packed_single_uops;
    logic [2:0] fp128_scalar_double_uops;
    logic [2:0] vec256_packed_single_instr;
    logic [2:0] vec256_packed_double_instr;
    logic       divider_active_cycles;
    logic [7:0] l2Requests;
    logic [3:0] storeLockAccess;
    logic [3:0] writebackAccess;
    logic       last_level_reference;
    logic       last_level_miss;
    logic       threadHalted;
    logic [3:0] outstanding_l1_misses;
    logic       store_xlat_miss_walk;
    logic       store_xlat_walk_done;
    logic       store_xlat_walk_cycles;
  } event_src_type;

endpackage : event_select_pkg

// File: logic/core_event_select_decoder.sv
`timescale 1ns/1ps
`include "event_select_map.svh"

module core_event_select_decoder
  import event_select_pkg::*;
(
  // Clock and reset.
  input  wire logic          sys_clk,
  input  wire logic          resetn,
  // Wishbone slave.
  input  wire logic          cyc_i,
  input  wire logic          stb_i,
  input  wire logic          we_i,
  input  wire logic [7:0]    adr_i,
  input  wire logic [3:0]    sel_i,
  input  wire logic [31:0]   dat_i,
  output logic      [31:0]   dat_o,
  output logic               ack_o,
  // Core event sources.
  input  wire event_src_type events,
  input  wire logic          reference_clock_100m,
  // Counter result.
  output logic      [31:0]   counterValue,
  output logic               countStep
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register bus.

  select_type   select_q;
  logic [31:0]  count_q;
  logic         ack_q;
  logic [31:0]  rdata_q;
  logic         access;
  logic         hitSelect;
  logic         hitCount;
  logic         hitStatus;
  logic         selectWrite;
  logic         countWrite;
  logic [31:0]  selectMerged;
  logic [31:0]  countMerged;
  logic         known;
  logic         above;
  logic         aboveLast_q;
  logic [4:0]   increment;
  logic         step;
  logic [31:0]  countAfter;

  assign access = cyc_i && stb_i && !ack_q;

  always_comb begin
    hitSelect = 1'b0;
    hitCount  = 1'b0;
    hitStatus = 1'b0;
    if (adr_i == `SELECT_ADDR) begin
      hitSelect = 1'b1;
    end else if (adr_i == `COUNT_ADDR) begin
      hitCount = 1'b1;
    end else if (adr_i == `STATUS_ADDR) begin
      hitStatus = 1'b1;
    end
  end

  assign selectWrite = access && we_i && hitSelect;
  assign countWrite  = access && we_i && hitCount;

  ////////////////////////////////////////////////////////////////////////////////
  // Byte lanes.

  // Lanes that sel_i leaves out keep their old contents, so software may
  // change the threshold byte without disturbing the event choice.
  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign selectMerged[b*8 +: 8] = sel_i[b] ? dat_i[b*8 +: 8] : select_q[b*8 +: 8];
    assign countMerged[b*8 +: 8]  = sel_i[b] ? dat_i[b*8 +: 8] : count_q[b*8 +: 8];
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= access;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      select_q <= `SELECT_RESET;
    end else if (selectWrite) begin
      select_q <= selectMerged;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (access && !we_i) begin
      if (hitSelect) begin
        rdata_q <= select_q;
      end else if (hitCount) begin
        rdata_q <= count_q;
      end else if (hitStatus) begin
        rdata_q <= {30'h0000_0000, aboveLast_q, known};
      end else begin
        rdata_q <= 32'h0000_0000;
      end
    end
  end

  assign dat_o = rdata_q;
  assign ack_o = ack_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Reference clock tick detection.

  // The reference runs faster than the core clock, so the outside divider
  // hands over a toggle that flips once per group of reference ticks.
  logic refSync1_q;
  logic refSync2_q;
  logic refSync3_q;
  logic refStable_q;
  logic refTick_q;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      refSync1_q <= 1'b0;
      refSync2_q <= 1'b0;
      refSync3_q <= 1'b0;
    end else begin
      refSync1_q <= reference_clock_100m;
      refSync2_q <= refSync1_q;
      refSync3_q <= refSync2_q;
    end
  end

  // The third stage only confirms the second, so a sample caught while the
  // pin moves is never counted on its own.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      refStable_q <= 1'b0;
      refTick_q   <= 1'b0;
    end else begin
      refTick_q <= 1'b0;
      if (refSync2_q == refSync3_q && refSync3_q != refStable_q) begin
        refStable_q <= refSync3_q;
        refTick_q   <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Event selection.

  function automatic logic [4:0] onesOf(input logic [7:0] bits);
    logic [4:0] total;
    total = 5'h00;
    for (int i = 0; i < 8; i++) begin
      total = total + {4'h0, bits[i]};
    end
    return total;
  endfunction : onesOf

  // An unknown selection holds the counter rather than counting a guess,
  // and software can see that in the status word.
  always_comb begin
    increment = 5'h00;
    known     = 1'b1;
    case (select_q.eventNum)
      `EV_FP128: begin
        if (select_q.unitMask[6]) begin
          increment = increment + {2'h0, events.fp128_packed_single_uops};
        end
        if (select_q.unitMask[7]) begin
          increment = increment + {2'h0, events.fp128_scalar_double_uops};
        end
      end
      `EV_VEC256: begin
        if (select_q.unitMask[0]) begin
          increment = increment + {2'h0, events.vec256_packed_single_instr};
        end
        if (select_q.unitMask[1]) begin
          increment = increment + {2'h0, events.vec256_packed_double_instr};
        end
      end
      `EV_DIVIDER: begin
        increment = {4'h0, select_q.unitMask[0] & events.divider_active_cycles};
      end
      `EV_L2_REQ: begin
        increment = onesOf(events.l2Requests & select_q.unitMask);
      end
      `EV_STORE_LOCK: begin
        increment = onesOf({4'h0, events.storeLockAccess & select_q.unitMask[3:0]});
      end
      `EV_WRITEBACK: begin
        increment = onesOf({4'h0, events.writebackAccess & select_q.unitMask[3:0]});
      end
      `EV_LAST_LEVEL: begin
        if (select_q.unitMask == `UM_LL_REFERENCE) begin
          increment = {4'h0, events.last_level_reference};
        end else if (select_q.unitMask == `UM_LL_MISS) begin
          increment = {4'h0, events.last_level_miss};
        end else begin
          known = 1'b0;
        end
      end
      `EV_UNHALTED: begin
        if (select_q.unitMask == `UM_CORE_CYCLES) begin
          increment = {4'h0, !events.threadHalted};
        end else if (select_q.unitMask == `UM_REF_CYCLES) begin
          if (refTick_q && !events.threadHalted) begin
            increment = `REF_TICKS_PER_TOGGLE;
          end
        end else begin
          known = 1'b0;
        end
      end
      `EV_L1_PENDING: begin
        if (select_q.counterIndex == `GENERAL_COUNTER_TWO && select_q.unitMask[0]) begin
          increment = {1'b0, events.outstanding_l1_misses};
        end else begin
          known = 1'b0;
        end
      end
      `EV_STORE_XLAT: begin
        increment = onesOf({5'h00, events.store_xlat_walk_cycles,
                            events.store_xlat_walk_done,
                            events.store_xlat_miss_walk} & select_q.unitMask);
      end
      default: begin
        known = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Threshold, edge and counter.

  // Edge mode with a zero threshold behaves as threshold one, so a plain
  // busy level still yields one count per rising occurrence.
  always_comb begin
    if (select_q.countMask == 8'h00) begin
      above = increment != 5'h00;
    end else begin
      above = {3'h0, increment} >= select_q.countMask;
    end
    if (select_q.edgeDetect) begin
      step = above && !aboveLast_q;
    end else begin
      step = select_q.countMask != 8'h00 ? above : 1'b0;
    end
  end

  always_comb begin
    if (select_q.edgeDetect || select_q.countMask != 8'h00) begin
      countAfter = count_q + {31'h0000_0000, step};
    end else begin
      countAfter = count_q + {27'h000_0000, increment};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      aboveLast_q <= 1'b0;
    end else begin
      aboveLast_q <= above;
    end
  end

  // A software write to the count wins over the increment of that cycle,
  // so a preset value is never off by one.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      count_q <= `COUNT_RESET;
    end else if (countWrite) begin
      count_q <= countMerged;
    end else if (select_q.enable && known) begin
      count_q <= countAfter;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      countStep <= 1'b0;
    end else begin
      // A preset write replaces the count, so that cycle is not reported as a step.
      countStep <= select_q.enable && known && !countWrite && countAfter != count_q;
    end
  end

  assign counterValue = count_q;

endmodule : core_event_select_decoder

// File: bench/core_event_select_decoder_properties.sv
`timescale 1ns/1ps
`include "event_select_map.svh"
module core_event_select_decoder_properties
  import event_select_pkg::*;
(
  // Clock and reset.
  input wire logic          sys_clk,
  input wire logic          resetn,
  // Register bus.
  input wire logic          cyc_i,
  input wire logic          stb_i,
  input wire logic          we_i,
  input wire logic [7:0]    adr_i,
  input wire logic [31:0]   dat_i,
  input wire logic [31:0]   dat_o,
  input wire logic          ack_o,
  // Events and counter.
  input wire event_src_type events,
  input wire logic [31:0]   counterValue,
  input wire logic          countStep
);
  select_type  shadowSel_q;
  logic        take;
  logic        counting;
  logic [3:0]  inc;
  logic [31:0] nextVal;
  assign take = cyc_i && stb_i && !ack_o;
  assign counting = shadowSel_q.enable && !shadowSel_q.edgeDetect && !(take && we_i);
  // Shadow of the selection, so counting relations need no view of the body.
  always_ff @(posedge sys_clk) begin
    if (!resetn) shadowSel_q <= '0;
    else if (take && we_i && adr_i == `SELECT_ADDR) shadowSel_q <= dat_i;
  end
  always_comb begin
    case (shadowSel_q[15:0])
      16'h4010: inc = {1'b0, events.fp128_packed_single_uops};
      16'h0114: inc = {3'h0, events.divider_active_cycles};
      16'h4F2E: inc = {3'h0, events.last_level_reference};
      default:  inc = 4'h0;
    endcase
    nextVal = counterValue + ((shadowSel_q.countMask == 8'h0) ? 32'(inc)
                              : 32'({4'h0, inc} >= shadowSel_q.countMask));
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  ack_answer_a: assert property (take |=> ack_o)
    else $error("ack missing after request");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  read_data_a: assert property (take && !we_i && adr_i == `COUNT_ADDR
    |=> dat_o == $past(counterValue)) else $error("count read wrong");
  count_write_a: assert property (take && we_i && adr_i == `COUNT_ADDR
    |=> counterValue == $past(dat_i)) else $error("count write lost");
  fp_count_a: assert property (
    counting && shadowSel_q[15:0] == 16'h4010 |=> counterValue == $past(nextVal))
    else $error("packed single count wrong");
  div_count_a: assert property (
    counting && shadowSel_q[15:0] == 16'h0114 |=> counterValue == $past(nextVal))
    else $error("divider count wrong");
  ll_ref_a: assert property (
    counting && shadowSel_q[15:0] == 16'h4F2E |=> counterValue == $past(nextVal))
    else $error("last level count wrong");
  pend_index_a: assert property (
    shadowSel_q.eventNum == `EV_L1_PENDING && shadowSel_q.counterIndex != 2'h2
    && !(take && we_i) |=> $stable(counterValue)) else $error("pending on wrong counter");
  hold_off_a: assert property (!shadowSel_q.enable && !(take && we_i)
    |=> $stable(counterValue)) else $error("disabled counter moved");
  step_flag_a: assert property (!(take && we_i && adr_i == `COUNT_ADDR)
    |=> countStep == (counterValue != $past(counterValue))) else $error("step flag wrong");
  cover property (take && we_i && adr_i == `COUNT_ADDR);
  cover property (counting && shadowSel_q.countMask != 8'h0);
  cover property (shadowSel_q.enable && shadowSel_q.eventNum == `EV_L1_PENDING);
endmodule : core_event_select_decoder_properties

// File: bench/event_source_model.sv
`timescale 1ns/1ps
module event_source_model
  import event_select_pkg::*;
(
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // Random pattern.
  input  wire logic [31:0] pattern,
  // Event sources.
  output event_src_type    events,
  output logic             reference_clock_100m
);
  logic [2:0] refCount_q;
  // One lock or writeback request is in one line state, so those stay one-hot or all zero.
  always_ff @(posedge sys_clk) begin
    events <= {pattern[6:0], pattern};
    events.storeLockAccess <= pattern[2] ? 4'h1 << pattern[1:0] : 4'h0;
    events.writebackAccess <= pattern[5] ? 4'h1 << pattern[4:3] : 4'h0;
  end
  // Free-running reference: eight core cycles hold sixteen reference ticks.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      refCount_q <= 3'h0;
      reference_clock_100m <= 1'b0;
    end else begin
      refCount_q <= refCount_q + 3'h1;
      if (refCount_q == 3'h7) reference_clock_100m <= !reference_clock_100m;
    end
  end
endmodule : event_source_model

// File: bench/core_event_select_decoder_tb.sv
`timescale 1ns/1ps
`include "event_select_map.svh"
module core_event_select_decoder_tb;
  import event_select_pkg::*;
  logic sys_clk = 0, resetn = 0, cyc = 0, stb = 0, we = 0, ack, step, refClk;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'hF;
  logic [31:0] dat = 32'h0, datO, cnt, rd, pattern = 32'h4297, seed = 32'h4297;
  logic [31:0] expCount = 32'h0;
  logic [4:0]  inc, addVal;
  logic        above, aboveLast = 0;
  select_type  shadow = '0;
  event_src_type events;
  int miscompares = 0, check_count = 0, cycles = 0, steps = 0, expSteps = 0;
  logic [31:0] cases [$] = '{32'h4010, 32'h8010, 32'h0200C010, 32'h0111, 32'h0211,
    32'h0114, 32'h01010114, 32'h0124, 32'h0424, 32'h0824, 32'h1024, 32'h2024,
    32'h4024, 32'h8024, 32'h0C24, 32'h3024, 32'h0324, 32'hC024, 32'h0127, 32'h0827,
    32'h0F27, 32'h0128, 32'h0428, 32'h0828, 32'h0F28, 32'h4F2E, 32'h412E, 32'h003C,
    32'h00080148, 32'h00040148, 32'h01090148, 32'h0149, 32'h0249, 32'h0449,
    32'h0150, 32'h03014010};
  always #10 sys_clk = !sys_clk;
  core_event_select_decoder uut (.sys_clk(sys_clk), .resetn(resetn), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(datO),
    .ack_o(ack), .events(events), .reference_clock_100m(refClk),
    .counterValue(cnt), .countStep(step));
  event_source_model partner (.sys_clk(sys_clk), .resetn(resetn), .pattern(pattern),
    .events(events), .reference_clock_100m(refClk));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  function automatic logic [4:0] incOf(input select_type s, input event_src_type e);
    logic [7:0] m;
    m = s.unitMask;
    case (s.eventNum)
      `EV_FP128: return (m[6] ? e.fp128_packed_single_uops : 5'h0)
        + (m[7] ? e.fp128_scalar_double_uops : 5'h0);
      `EV_VEC256: return (m[0] ? e.vec256_packed_single_instr : 5'h0)
        + (m[1] ? e.vec256_packed_double_instr : 5'h0);
      `EV_DIVIDER: return {4'h0, m[0] & e.divider_active_cycles};
      `EV_L2_REQ: return $countones(e.l2Requests & m);
      `EV_STORE_LOCK: return $countones(e.storeLockAccess & m[3:0]);
      `EV_WRITEBACK: return $countones(e.writebackAccess & m[3:0]);
      `EV_LAST_LEVEL: return m == 8'h4F ? e.last_level_reference
        : m == 8'h41 ? e.last_level_miss : 1'b0;
      `EV_UNHALTED: return m == 8'h00 ? !e.threadHalted : 1'b0;
      `EV_L1_PENDING: return s.counterIndex == `GENERAL_COUNTER_TWO
        ? e.outstanding_l1_misses : 4'h0;
      `EV_STORE_XLAT: return $countones({e.store_xlat_walk_cycles,
        e.store_xlat_walk_done, e.store_xlat_miss_walk} & m[2:0]);
      default: return 5'h0;
    endcase
  endfunction : incOf
  //////////////////////////////////////////////////////////////////////////////
  // Expected count follows the bus at the same edges the slave takes requests.
  always @(posedge sys_clk) begin
    if (!resetn) begin
      shadow = '0;
      expCount = 32'h0;
      aboveLast = 0;
    end else begin
      inc = incOf(shadow, events);
      above = {3'h0, inc} >= (shadow.countMask == 8'h0 ? 8'h01 : shadow.countMask);
      addVal = shadow.edgeDetect ? 5'(above && !aboveLast)
        : shadow.countMask == 8'h0 ? inc : 5'(above);
      if (shadow.enable) expCount += addVal;
      if (shadow.enable && addVal != 5'h0
          && !(cyc && stb && we && !ack && adr == `COUNT_ADDR)) expSteps++;
      if (step === 1'b1) steps++;
      aboveLast = above;
      if (cyc && stb && we && !ack && adr == `SELECT_ADDR) shadow = dat;
      if (cyc && stb && we && !ack && adr == `COUNT_ADDR) expCount = dat;
    end
    pattern <= lfsr(pattern);
  end
  always @(posedge sys_clk) if (++cycles == 20000) begin
    miscompares++;
    final_report();
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    do @(posedge sys_clk); while (ack !== 1'b1);
    rd = datO;
    {cyc, stb} <= 2'b00;
  endtask : bus
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  //////////////////////////////////////////////////////////////////////////////
  // Selection 0 between cases clears the above-threshold history on both sides.
  task automatic run(input logic [31:0] s, input logic [31:0] preset, input int len);
    bus(1, `COUNT_ADDR, preset);
    bus(1, `SELECT_ADDR, s | 32'h0002_0000);
    repeat (len) @(posedge sys_clk);
    bus(1, `SELECT_ADDR, 32'h0);
    bus(0, `COUNT_ADDR, 32'h0);
  endtask : run
  initial begin
    repeat (16) @(posedge sys_clk);
    resetn <= 1;
    foreach (cases[i]) begin
      seed = lfsr(seed);
      run(cases[i], {8'h00, seed[23:0]}, 40);
      chk(rd, expCount);
      chk(steps, expSteps);
    end
    run(32'h013C, 32'h0, 80);
    chk(32'(rd[3:0] == 4'h0 && rd != 32'h0), 32'h1);
    bus(0, 8'h0C, 32'h0);
    chk(rd, 32'h0);
    bus(1, `SELECT_ADDR, 32'h0114);
    bus(0, `STATUS_ADDR, 32'h0);
    chk(32'(rd[`STATUS_KNOWN]), 32'h1);
    final_report();
  end
endmodule : core_event_select_decoder_tb
bind core_event_select_decoder core_event_select_decoder_properties props (
  .sys_clk(sys_clk), .resetn(resetn), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .events(events),
  .counterValue(counterValue), .countStep(countStep));
